/* pkg/btsu_map.vh */
`ifndef BTSU_MAP_VH
`define BTSU_MAP_VH
// ----------------------------------------
// Instruction layout
// ----------------------------------------
`define BTSU_OPC_HI      11
`define BTSU_OPC_LO      8
`define BTSU_BIT_HI      7
`define BTSU_BIT_LO      5
`define BTSU_REG_HI      4
`define BTSU_REG_LO      0
`define BTSU_OPC_SKIP_CLR 4'h6
`define BTSU_OPC_SKIP_SET 4'h7
// Fetched word that executes as a no-operation
`define BTSU_NOP_WORD    12'h000
// Total cycles of a skipping instruction
`define BTSU_SKIP_CYCLES 2
`endif

/* logic/btsu_bit_select.v */
`include "btsu_map.vh"
// ----------------------------------------
// Bit selector
// ----------------------------------------
module btsu_bit_select (
  input  wire [7:0] data,
  input  wire [2:0] index,
  output wire       bit_value
);
  // One mux; any index 0..7 is legal
  assign bit_value = data[index];
endmodule // btsu_bit_select

/* logic/btsu_core.v */
// Contract
// RQ1 - Opcode 0110 tests bit, skips when clear
// RQ2 - Opcode 0111 tests bit, skips when set
// RQ3 - Skip discards prefetch, runs no-operation instead
// RQ4 - Register 0..31 and bit 0..7 accepted
// RQ5 - Skip-if-clear decides only on bit zero
// RQ6 - No skip: one cycle, no writes
`include "btsu_map.vh"
// ----------------------------------------
// Bit-test-and-skip execute stage
// ----------------------------------------
module btsu_core (
  input  wire        clock,
  input  wire        rst,
  input  wire        exec_valid,
  input  wire [11:0] exec_word,
  input  wire [11:0] prefetch_word,
  input  wire [7:0]  file_rdata,
  output wire [4:0]  file_raddr,
  output wire        file_we,
  output wire        status_we,
  output wire        is_bit_test,
  output wire        skip_now,
  output reg  [11:0] next_exec_word,
  output reg         in_skip_cycle
);
  // ----------------------------------------
  // Decode
  // ----------------------------------------
  localparam ST_RUN  = 1'b0;
  localparam ST_SKIP = 1'b1;
  reg        state;
  wire [3:0] opcode;
  wire [2:0] bit_index;
  wire       sel_bit;
  wire       is_clr;
  wire       is_set;
  assign opcode     = exec_word[`BTSU_OPC_HI:`BTSU_OPC_LO];
  assign bit_index  = exec_word[`BTSU_BIT_HI:`BTSU_BIT_LO];              // see RQ4
  assign file_raddr = exec_word[`BTSU_REG_HI:`BTSU_REG_LO];              // see RQ4
  assign is_clr     = exec_valid && (opcode == `BTSU_OPC_SKIP_CLR);      // see RQ1
  assign is_set     = exec_valid && (opcode == `BTSU_OPC_SKIP_SET);      // see RQ2
  assign is_bit_test = is_clr || is_set;
  btsu_bit_select u_sel (
    .data      (file_rdata),
    .index     (bit_index),
    .bit_value (sel_bit)
  );
  // Skip decision; clear variant looks only at the bit being zero
  // Gated by run state: the nop slot never starts a second skip
  assign skip_now = (state == ST_RUN)
                 && ((is_clr && !sel_bit)                                // see RQ1 RQ5
                  || (is_set && sel_bit));                               // see RQ2
  // Tests never write the register or flags
  assign file_we   = 1'b0;                                               // see RQ6
  assign status_we = 1'b0;                                               // see RQ6
  // ----------------------------------------
  // Prefetch replacement
  // ----------------------------------------
  reg        next_state;
  reg [11:0] next_word;
  reg        next_slot;
  // Next values; defaults first so every path assigns all three
  always @*
  begin
    next_state = ST_RUN;
    next_word  = prefetch_word;
    next_slot  = 1'b0;
    case (state)
      ST_RUN:
      begin
        if (skip_now)
        begin
          next_state = ST_SKIP;
          next_word  = `BTSU_NOP_WORD;                                   // see RQ3
          next_slot  = 1'b1;
        end
        else
        begin
          next_state = ST_RUN;
          next_word  = prefetch_word;                                    // see RQ5 RQ6
          next_slot  = 1'b0;
        end
      end
      ST_SKIP:
      begin
        // No-operation slot cannot itself skip
        next_state = ST_RUN;
        next_word  = prefetch_word;
        next_slot  = 1'b0;
      end
      default:
      begin
        next_state = ST_RUN;
        next_word  = `BTSU_NOP_WORD;
        next_slot  = 1'b0;
      end
    endcase
  end
  // Registered so the next stage sees a clean word; skip costs one extra cycle
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      state          <= ST_RUN;
      next_exec_word <= `BTSU_NOP_WORD;
      in_skip_cycle  <= 1'b0;
    end
    else
    begin
      state          <= next_state;
      next_exec_word <= next_word;
      in_skip_cycle  <= next_slot;
    end
  end
endmodule // btsu_core

/* tb/btsu_regfile.sv */
module btsu_regfile (input wire logic [4:0] file_raddr, output logic [7:0] file_rdata);
  timeunit 1ns; timeprecision 100ps;
  // Combinational read; bench loads mem
  logic [7:0] mem [32];
  assign file_rdata = mem[file_raddr];
endmodule // btsu_regfile

/* tb/btsu_chk.sv */
module btsu_chk (input wire logic clock, rst, exec_valid, skip_now, in_skip_cycle, file_we,
  status_we, input wire logic [11:0] exec_word, prefetch_word, next_exec_word,
  input wire logic [7:0] file_rdata, input wire logic [4:0] file_raddr);
  timeunit 1ns; timeprecision 100ps;
  // A test counts outside the nop slot only
  wire live = exec_valid && !in_skip_cycle && exec_word[11:9] == 3'h3;
  wire hit = file_rdata[exec_word[7:5]];
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  a_clear_skip: assert property (live && !exec_word[8] |-> skip_now != hit)
    else $error("clear");
  a_set_skip: assert property (live && exec_word[8] |-> skip_now == hit)
    else $error("set");
  a_nop_slot: assert property (skip_now |=> in_skip_cycle && !next_exec_word)
    else $error("nop");
  a_pass_on: assert property (exec_valid && !skip_now && !in_skip_cycle |=>
    next_exec_word == $past(prefetch_word)) else $error("pass");
  a_reg_addr: assert property (file_raddr == exec_word[4:0]) else $error("addr");
  a_no_write: assert property (!file_we && !status_we) else $error("write");
endmodule // btsu_chk
bind btsu_core btsu_chk u_btsu_chk (.*);

/* tb/btsu_core_bench.sv */
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin miscompares++; \
  $display("ERROR %s exp %h got %h", n, e, s); end end
module btsu_core_bench;
  timeunit 1ns; timeprecision 100ps;
  logic clock = 0, rst = 1, exec_valid = 0, skip_now, in_skip_cycle, file_we, status_we;
  logic [11:0] exec_word = 0, prefetch_word = 0, next_exec_word;
  logic [7:0] file_rdata;
  logic [4:0] file_raddr;
  logic is_bit_test;
  int miscompares = 0, comparisons = 0;
  always #12.5 clock = ~clock;
  btsu_core u_btsu_core (.*);
  btsu_regfile u_btsu_regfile (.*);
  // Starts at a falling edge; a skip also walks the nop slot
  task step(input [11:0] w, p, input s);
    exec_valid = 1; exec_word = w; prefetch_word = p;
    #1 `CHK("skip", s, skip_now)
    `CHK("decode", 1'b1, is_bit_test)
    @(negedge clock) `CHK("next", s ? 12'h000 : p, next_exec_word)
    `CHK("slot", s, in_skip_cycle)
    if (s) begin #1 `CHK("reskip", 1'b0, skip_now)
      @(negedge clock) `CHK("after", p, next_exec_word); end
  endtask
  // Other opcodes and an idle stage never skip
  task t_other;
    u_btsu_regfile.mem[3] = 8'h00; exec_valid = 1; exec_word = 12'h403;
    #1 `CHK("other skip", 1'b0, skip_now)
    `CHK("other decode", 1'b0, is_bit_test)
    @(negedge clock) exec_valid = 0; exec_word = 12'h603;
    #1 `CHK("idle skip", 1'b0, skip_now)
    @(negedge clock) exec_valid = 1;
  endtask
  // Each bit index of one register, both bit values
  task t_test(input [3:0] op, input [4:0] r);
    for (int b = 0; b < 8; b++) for (int v = 0; v < 2; v++) begin
      u_btsu_regfile.mem[r] = v ? 8'h01 << b : ~(8'h01 << b);
      step({op, b[2:0], r}, {4'h5, r, b[2:0]}, v == (op == 4'h7));
    end
  endtask
  task summarize; if (miscompares == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN"); $finish; endtask
  initial begin repeat (10) @(negedge clock); rst = 0;
    t_test(4'h6, 5'h1f); t_test(4'h7, 5'h00); t_other; summarize; end
endmodule // btsu_core_bench
